// *** hdl/lpm_pkg.sv ***
// Package for the low-power mode controller: register map, field
// positions, reset values and timing counts.
// Assumes a single 200 MHz clock domain and a nibble-wide bit-access port.
package lpm_pkg;

    // Clock and timing
    localparam int CLK_PERIOD_PS = 5000;
    // Oscillator stabilisation time, least value; plain default
    localparam int STAB_TIME_NS = 1000;
    localparam int STAB_CYCLES = (STAB_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int STAB_CNT_W = $clog2(STAB_CYCLES + 1);

    // System clock divide ratios chosen by the strap pin
    localparam int DIV_FAST = 4;
    localparam int DIV_SLOW = 32;
    localparam int DIV_CNT_W = 5;

    // Control bit addresses (nibble locations)
    localparam int ADDR_W = 10;
    localparam logic [9:0] ADDR_GATE = 10'h000;
    localparam logic [9:0] ADDR_TMR_C = 10'h002;
    localparam logic [9:0] ADDR_TMR_D_SER = 10'h003;
    localparam logic [9:0] ADDR_RETAIN = 10'h021;

    // Bit positions
    localparam int BIT_GATE = 0;
    localparam int BIT_TC_FLAG = 2;
    localparam int BIT_TC_MASK = 3;
    localparam int BIT_TD_FLAG = 0;
    localparam int BIT_TD_MASK = 1;
    localparam int BIT_SER_FLAG = 2;
    localparam int BIT_SER_MASK = 3;
    localparam int BIT_RETAIN = 3;

    // Values after reset
    localparam logic RST_GATE = 1'b0;
    localparam logic RST_FLAG = 1'b0;
    localparam logic RST_MASK = 1'b1;
    localparam logic RST_RETAIN = 1'b0;
    localparam logic RST_DIV_FAST = 1'b1;

    typedef enum logic [1:0] {
        LPM_ACTIVE,
        LPM_STANDBY,
        LPM_STOP
    } lpm_mode_t;

endpackage

// *** hdl/lpm_clk_if.sv ***
// Interface between the mode controller and its system clock divider.
// Assumes both ends share one clock.
`timescale 1ns/100ps
`default_nettype none
interface lpm_clk_if;
    logic div_fast;
    logic run;
    logic tick;
    modport ctl (output div_fast, output run, input tick);
    modport div (input div_fast, input run, output tick);
endinterface
`default_nettype wire

// *** hdl/lpm_clk_div.sv ***
// System clock divider: one instruction tick every 4 or 32 clocks.
// Assumes the controller drops run in standby and stop.
`timescale 1ns/100ps
`default_nettype none
module lpm_clk_div
    import lpm_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Control side
    lpm_clk_if.div ctl
);

    logic [DIV_CNT_W-1:0] count;
    logic [DIV_CNT_W-1:0] last;

    assign last = ctl.div_fast ? DIV_CNT_W'(DIV_FAST - 1) : DIV_CNT_W'(DIV_SLOW - 1);

    // Count restarts when gated so the first tick after wake is a full period
    always_ff @(posedge clk) begin
        if (sys_rst || !ctl.run || count >= last) begin
            count <= '0;
        end else begin
            count <= count + DIV_CNT_W'(1);
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ctl.tick <= 1'b0;
        end else begin
            ctl.tick <= ctl.run && (count == last);
        end
    end

endmodule
`default_nettype wire

// *** hdl/lpm_ctrl.sv ***
// Low-power mode controller: wake-source flags and masks, global gate,
// active/standby/stop machine, retention indicator and clock strap.
// Assumes CPU accesses come as synchronous one-cycle bit-access strobes.
`timescale 1ns/100ps
`default_nettype none
module lpm_ctrl
    import lpm_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // CPU bit-access port
    input wire logic [ADDR_W-1:0] cpu_addr,
    input wire logic cpu_wr,
    input wire logic [3:0] cpu_wr_mask,
    input wire logic [3:0] cpu_wr_data,
    input wire logic cpu_rd,
    output logic [3:0] cpu_rd_data,
    output logic cpu_rd_hit,
    // CPU instruction events
    input wire logic standby_instruction,
    input wire logic stop_instruction,
    // Wake sources
    input wire logic timer_c_ovf,
    input wire logic timer_d_ovf,
    input wire logic timer_d_capture_on,
    input wire logic timer_d_capture_rise,
    input wire logic timer_d_event_pin,
    input wire logic serial_done,
    input wire logic serial_suspend,
    input wire logic other_req_pending,
    // Pins
    input wire logic stop_cancel_pin_n,
    input wire logic clk_sel_strap,
    // Mode outputs
    output logic [1:0] mode,
    output logic instr_clk_en,
    output logic instr_tick,
    output logic osc_en,
    output logic periph_reset,
    output logic comparator_halt,
    output logic pins_hiz,
    output logic pin_func_cancel,
    output logic div_fast,
    output logic fetch_restart,
    output logic resume_next,
    output logic instr_nop,
    output logic irq_req
);

    ////////////////////////////////////////////////////////////////////
    // State

    lpm_mode_t state;
    lpm_mode_t next_state;
    logic global_irq_gate;
    logic timer_c_request_flag;
    logic timer_c_request_mask;
    logic timer_d_request_flag;
    logic timer_d_request_mask;
    logic serial_request_flag;
    logic serial_request_mask;
    logic ram_retention_indicator;
    logic evt_prev;
    logic [STAB_CNT_W-1:0] stab_cnt;
    logic pending;
    logic nop_case;
    logic cancel_done;
    logic capture_edge;
    logic wr_tc;
    logic wr_tds;
    logic wr_gate;
    logic wr_ret;

    lpm_clk_if clk_bus ();

    lpm_clk_div u_div (
        .clk(clk),
        .sys_rst(sys_rst),
        .ctl(clk_bus.div)
    );

    assign clk_bus.div_fast = div_fast;
    assign clk_bus.run = (state == LPM_ACTIVE) && !sys_rst;

    ////////////////////////////////////////////////////////////////////
    // Request logic

    // request equals flag and not mask
    assign pending = (timer_c_request_flag && !timer_c_request_mask)
        || (timer_d_request_flag && !timer_d_request_mask)
        || (serial_request_flag && !serial_request_mask)
        || other_req_pending;

    assign nop_case = !global_irq_gate && pending;

    assign capture_edge = timer_d_capture_on
        && (timer_d_capture_rise ? (timer_d_event_pin && !evt_prev)
                                 : (!timer_d_event_pin && evt_prev));

    // cancel must be held a full stabilisation time
    assign cancel_done = (stab_cnt == STAB_CNT_W'(STAB_CYCLES));

    assign wr_gate = cpu_wr && (cpu_addr == ADDR_GATE);
    assign wr_tc = cpu_wr && (cpu_addr == ADDR_TMR_C);
    assign wr_tds = cpu_wr && (cpu_addr == ADDR_TMR_D_SER);
    assign wr_ret = cpu_wr && (cpu_addr == ADDR_RETAIN);

    always_ff @(posedge clk) begin
        // Follow the pin in reset so a high pin gives no false edge after it
        if (sys_rst) begin
            evt_prev <= timer_d_event_pin;
        end else begin
            evt_prev <= timer_d_event_pin;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Flags: software may only clear; a set in the same cycle wins

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            timer_c_request_flag <= RST_FLAG;
        end else if (timer_c_ovf) begin
            timer_c_request_flag <= 1'b1;
        end else if (wr_tc && cpu_wr_mask[BIT_TC_FLAG] && !cpu_wr_data[BIT_TC_FLAG]) begin
            timer_c_request_flag <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            timer_d_request_flag <= RST_FLAG;
        end else if (timer_d_ovf || capture_edge) begin
            timer_d_request_flag <= 1'b1;
        end else if (wr_tds && cpu_wr_mask[BIT_TD_FLAG] && !cpu_wr_data[BIT_TD_FLAG]) begin
            timer_d_request_flag <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            serial_request_flag <= RST_FLAG;
        end else if (serial_done || serial_suspend) begin
            serial_request_flag <= 1'b1;
        end else if (wr_tds && cpu_wr_mask[BIT_SER_FLAG] && !cpu_wr_data[BIT_SER_FLAG]) begin
            serial_request_flag <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Masks and gate

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            timer_c_request_mask <= RST_MASK;
            timer_d_request_mask <= RST_MASK;
            serial_request_mask <= RST_MASK;
        end else begin
            if (wr_tc && cpu_wr_mask[BIT_TC_MASK]) begin
                timer_c_request_mask <= cpu_wr_data[BIT_TC_MASK];
            end
            if (wr_tds && cpu_wr_mask[BIT_TD_MASK]) begin
                timer_d_request_mask <= cpu_wr_data[BIT_TD_MASK];
            end
            if (wr_tds && cpu_wr_mask[BIT_SER_MASK]) begin
                serial_request_mask <= cpu_wr_data[BIT_SER_MASK];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            global_irq_gate <= RST_GATE;
        end else if (wr_gate && cpu_wr_mask[BIT_GATE]) begin
            global_irq_gate <= cpu_wr_data[BIT_GATE];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Retention indicator

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ram_retention_indicator <= RST_RETAIN;
        end else if (state == LPM_STOP && cancel_done) begin
            ram_retention_indicator <= 1'b1;
        end else if (wr_ret && cpu_wr_mask[BIT_RETAIN]) begin
            ram_retention_indicator <= cpu_wr_data[BIT_RETAIN];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Read port, answer one cycle after the strobe

    always_ff @(posedge clk) begin
        if (sys_rst || !cpu_rd) begin
            cpu_rd_data <= 4'h0;
            cpu_rd_hit <= 1'b0;
        end else if (cpu_addr == ADDR_GATE) begin
            cpu_rd_data <= {3'h0, global_irq_gate};
            cpu_rd_hit <= 1'b1;
        end else if (cpu_addr == ADDR_TMR_C) begin
            cpu_rd_data <= {timer_c_request_mask, timer_c_request_flag, 2'h0};
            cpu_rd_hit <= 1'b1;
        end else if (cpu_addr == ADDR_TMR_D_SER) begin
            cpu_rd_data <= {serial_request_mask, serial_request_flag,
                            timer_d_request_mask, timer_d_request_flag};
            cpu_rd_hit <= 1'b1;
        end else if (cpu_addr == ADDR_RETAIN) begin
            cpu_rd_data <= {ram_retention_indicator, 3'h0};
            cpu_rd_hit <= 1'b1;
        end else begin
            // Other RAM locations belong to the data memory
            cpu_rd_data <= 4'h0;
            cpu_rd_hit <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Mode machine

    always_comb begin
        next_state = state;
        case (state)
            LPM_ACTIVE: begin
                if (stop_instruction && !nop_case) begin
                    next_state = LPM_STOP;
                end else if (standby_instruction && !nop_case) begin
                    next_state = LPM_STANDBY;
                end
            end
            LPM_STANDBY: begin
                // any request wakes, gate only decides service
                if (pending) begin
                    next_state = LPM_ACTIVE;
                end
            end
            LPM_STOP: begin
                if (cancel_done) begin
                    next_state = LPM_ACTIVE;
                end
            end
            default: begin
                next_state = LPM_ACTIVE;
            end
        endcase
    end

    // standby left by reset is a full reset
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state <= LPM_ACTIVE;
        end else begin
            state <= next_state;
        end
    end

    // Oscillator stabilisation count while cancel is held in stop
    always_ff @(posedge clk) begin
        if (sys_rst || state != LPM_STOP || stop_cancel_pin_n) begin
            stab_cnt <= '0;
        end else if (!cancel_done) begin
            stab_cnt <= stab_cnt + STAB_CNT_W'(1);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Mode outputs registered from next_state; instr_tick registered from the divider tick

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            mode <= 2'(LPM_ACTIVE);
            instr_clk_en <= 1'b0;
            osc_en <= 1'b1;
            periph_reset <= 1'b1;
            comparator_halt <= 1'b0;
            pins_hiz <= 1'b0;
            pin_func_cancel <= 1'b0;
        end else begin
            mode <= 2'(next_state);
            // only instruction clocks gated and comparator halted in standby
            instr_clk_en <= (next_state == LPM_ACTIVE);
            osc_en <= (next_state != LPM_STOP);
            // stop holds peripherals reset, pins floating
            periph_reset <= (next_state == LPM_STOP);
            pins_hiz <= (next_state == LPM_STOP);
            pin_func_cancel <= (next_state == LPM_STOP);
            comparator_halt <= (next_state != LPM_ACTIVE);
        end
    end

    always_ff @(posedge clk) begin
        instr_tick <= sys_rst ? 1'b0 : clk_bus.tick;
    end

    ////////////////////////////////////////////////////////////////////
    // Event pulses

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            fetch_restart <= 1'b1;
            resume_next <= 1'b0;
            instr_nop <= 1'b0;
            irq_req <= 1'b0;
        end else begin
            // stop exit fetches from address zero
            fetch_restart <= (state == LPM_STOP) && cancel_done;
            resume_next <= (state == LPM_STANDBY) && pending;
            instr_nop <= (state == LPM_ACTIVE) && nop_case
                && (stop_instruction || standby_instruction);
            irq_req <= (next_state == LPM_ACTIVE) && global_irq_gate && pending;
        end
    end

    // strap caught the cycle after reset or stop exit
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            div_fast <= RST_DIV_FAST;
        end else if (fetch_restart) begin
            div_fast <= clk_sel_strap;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Checks

    a_flag_set_wins: assert property (@(posedge clk) disable iff (sys_rst)
        (serial_done || serial_suspend) |=> serial_request_flag)
        else $error("serial flag not set by transfer event");

    a_capture_sets_d: assert property (@(posedge clk) disable iff (sys_rst)
        (timer_d_capture_on && timer_d_capture_rise && timer_d_event_pin
         && !$past(timer_d_event_pin)) |=> timer_d_request_flag)
        else $error("capture edge did not set timer D flag");

    a_mask_c_blocks: assert property (@(posedge clk) disable iff (sys_rst)
        (state == LPM_STANDBY && timer_c_request_mask && !timer_d_request_flag
         && !serial_request_flag && !other_req_pending) |=> state == LPM_STANDBY)
        else $error("masked source woke standby");

    a_wake_standby: assert property (@(posedge clk) disable iff (sys_rst)
        (state == LPM_STANDBY && timer_d_request_flag && !timer_d_request_mask)
        |=> (mode == 2'(LPM_ACTIVE)) && resume_next && instr_clk_en)
        else $error("unmasked request did not wake standby");

    a_stop_outputs: assert property (@(posedge clk) disable iff (sys_rst)
        (mode == 2'(LPM_STOP)) |-> (!osc_en && periph_reset && pins_hiz && pin_func_cancel))
        else $error("stop mode outputs wrong");

    a_nop_stays: assert property (@(posedge clk) disable iff (sys_rst)
        (state == LPM_ACTIVE && stop_instruction && nop_case)
        |=> (state == LPM_ACTIVE) && instr_nop)
        else $error("instruction not cancelled");

    a_cancel_ignored: assert property (@(posedge clk) disable iff (sys_rst)
        (state != LPM_STOP && !stop_cancel_pin_n) |=> stab_cnt == '0 && !fetch_restart)
        else $error("cancel acted outside stop");

    a_cancel_exit: assert property (@(posedge clk) disable iff (sys_rst)
        (state == LPM_STOP && cancel_done)
        |=> (state == LPM_ACTIVE) && ram_retention_indicator && fetch_restart)
        else $error("cancel exit wrong");

    a_strap_taken: assert property (@(posedge clk) disable iff (sys_rst)
        fetch_restart |=> div_fast == $past(clk_sel_strap))
        else $error("strap not sampled");

    a_standby_clocks: assert property (@(posedge clk) disable iff (sys_rst)
        (mode == 2'(LPM_STANDBY)) |-> (!instr_clk_en && osc_en && comparator_halt))
        else $error("standby clock gating wrong");

endmodule
`default_nettype wire

// *** dv/lpm_pin_model.sv ***
// Outside pin model: drives the stop-cancel pin.
// Assumes each hold is commanded by a one-cycle start pulse.
`timescale 1ns/100ps
`default_nettype none
module lpm_pin_model (
    // Clock
    input wire logic clk,
    // Command
    input wire logic start,
    input wire logic [9:0] hold_len,
    // Pin
    output logic stop_cancel_pin_n
);
    logic [9:0] left = 10'h000;

    always_ff @(posedge clk) begin
        if (start) begin
            left <= hold_len;
        end else if (left != 10'h000) begin
            left <= left - 10'h001;
        end
    end

    // Released pin rests at its pull-up level
    assign stop_cancel_pin_n = (left == 10'h000);
endmodule
`default_nettype wire

// *** dv/test_low_power_mode_control.sv ***
// Bench for the low-power mode controller.
// Assumes the pin model drives stop-cancel; all else driven here.
`timescale 1ns/100ps
`default_nettype none
module test_low_power_mode_control import lpm_pkg::*;;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [ADDR_W-1:0] cpu_addr = '0;
    logic cpu_wr = 1'b0, cpu_rd = 1'b0, rd_prev = 1'b0;
    logic [3:0] cpu_wr_mask = 4'h0, cpu_wr_data = 4'h0, cpu_rd_data, seen;
    logic cpu_rd_hit, standby_instruction = 1'b0, stop_instruction = 1'b0;
    logic timer_c_ovf = 1'b0, timer_d_ovf = 1'b0, timer_d_capture_on = 1'b0;
    logic timer_d_capture_rise = 1'b0, timer_d_event_pin = 1'b0;
    logic serial_done = 1'b0, serial_suspend = 1'b0, other_req_pending = 1'b0;
    logic stop_cancel_pin_n, clk_sel_strap = 1'b1, hold_start = 1'b0;
    logic [9:0] hold_len = 10'h000;
    logic [1:0] mode;
    logic instr_clk_en, instr_tick, osc_en, periph_reset, comparator_halt;
    logic pins_hiz, pin_func_cancel, div_fast, fetch_restart;
    logic resume_next, instr_nop, irq_req;
    int num_errors = 0, compares = 0;
    int seed = 32'h2836DECF;
    logic [4:0] exp_q [$];
    logic [9:0] sa [5] = '{ADDR_TMR_C, ADDR_TMR_D_SER, ADDR_TMR_D_SER, ADDR_TMR_D_SER,
        ADDR_TMR_D_SER};
    logic [3:0] fbit [5] = '{4'h4, 4'h1, 4'h1, 4'h4, 4'h4};
    logic [3:0] mbit [5] = '{4'h8, 4'h2, 4'h2, 4'h8, 4'h8};
    logic [3:0] bval [5] = '{4'h8, 4'hA, 4'hA, 4'hA, 4'hA};

    lpm_ctrl i_lpm_ctrl (
        .clk, .sys_rst, .cpu_addr, .cpu_wr, .cpu_wr_mask, .cpu_wr_data, .cpu_rd,
        .cpu_rd_data, .cpu_rd_hit, .standby_instruction, .stop_instruction,
        .timer_c_ovf, .timer_d_ovf, .timer_d_capture_on, .timer_d_capture_rise,
        .timer_d_event_pin, .serial_done, .serial_suspend, .other_req_pending,
        .stop_cancel_pin_n, .clk_sel_strap, .mode, .instr_clk_en, .instr_tick,
        .osc_en, .periph_reset, .comparator_halt, .pins_hiz, .pin_func_cancel,
        .div_fast, .fetch_restart, .resume_next, .instr_nop, .irq_req
    );
    lpm_pin_model i_lpm_pin_model (
        .clk(clk), .start(hold_start), .hold_len(hold_len),
        .stop_cancel_pin_n(stop_cancel_pin_n)
    );

    always #2.5 clk = ~clk;

    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic print_verdict();
        $display("Counts: compares=%0d mismatches=%0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask

    task automatic pulse(ref logic s);
        s = 1'b1;
        cyc(1);
        s = 1'b0;
    endtask

    task automatic wr(input logic [9:0] a, input logic [3:0] m, input logic [3:0] d);
        cpu_addr = a;
        cpu_wr_mask = m;
        cpu_wr_data = d;
        pulse(cpu_wr);
        // Let an edge pass so a following strobe is a fresh rise
        cyc(1);
    endtask

    // Expected answer is queued; the watcher pops it
    task automatic rd(input logic [9:0] a, input logic [4:0] e);
        cpu_addr = a;
        exp_q.push_back(e);
        pulse(cpu_rd);
        cyc(1);
    endtask

    task automatic fire(input int i);
        int r;
        case (i)
            0: pulse(timer_c_ovf);
            1: pulse(timer_d_ovf);
            2: begin
                r = $random(seed);
                timer_d_capture_rise = r[0];
                timer_d_event_pin = ~r[0];
                cyc(2);
                timer_d_capture_on = 1'b1;
                cyc(1);
                timer_d_event_pin = r[0];
                cyc(1);
                timer_d_capture_on = 1'b0;
            end
            3: pulse(serial_done);
            default: pulse(serial_suspend);
        endcase
        cyc(1);
    endtask

    // Sticky record: resume, irq, restart, nop
    task automatic wait_mode(input logic [1:0] m);
        int k;
        for (k = 0; k < 400 && mode !== m; k++) begin
            cyc(1);
        end
        seen = 4'h0;
        repeat (3) begin
            seen = seen | {resume_next, irq_req, fetch_restart, instr_nop};
            cyc(1);
        end
        check({6'h0, mode}, {6'h0, m});
    endtask

    // Ticks seen over n clocks of active mode
    task automatic count_ticks(input int n, input int per);
        logic [7:0] t;
        t = 8'h00;
        repeat (n) begin
            t = t + {7'h0, instr_tick};
            cyc(1);
        end
        check(t, 8'(n / per));
    endtask

    task automatic do_reset();
        sys_rst = 1'b1;
        cyc(3);
        check({5'h0, mode, fetch_restart}, 8'h01);
        sys_rst = 1'b0;
        cyc(1);
    endtask

    always @(posedge clk) begin
        rd_prev <= cpu_rd;
    end

    always @(negedge clk) begin
        if (rd_prev) begin
            check({3'h0, cpu_rd_hit, cpu_rd_data}, {3'h0, exp_q.pop_front()});
        end
    end

    ////////////////////////////////////////////////////////////////////////
    initial begin
        int i;
        int r;
        logic g;
        do_reset();
        cyc(1);
        check({7'h0, div_fast}, 8'h01);
        count_ticks(32, DIV_FAST);
        wr(ADDR_TMR_D_SER, 4'h5, 4'h5);
        rd(ADDR_GATE, 5'h10);
        rd(ADDR_TMR_C, 5'h18);
        rd(ADDR_TMR_D_SER, 5'h1A);
        rd(ADDR_RETAIN, 5'h10);
        rd(10'h3FF, 5'h00);
        for (i = 0; i < 5; i++) begin
            fire(i);
            rd(sa[i], {1'b1, bval[i] | fbit[i]});
            wr(sa[i], fbit[i], 4'h0);
            rd(sa[i], {1'b1, bval[i]});
        end
        $display("test flags done");
        for (i = 0; i < 5; i++) begin
            pulse(standby_instruction);
            check({6'h0, mode}, 8'h01);
            check({5'h0, instr_clk_en, osc_en, comparator_halt}, 8'h03);
            fire(i);
            cyc(4);
            check({6'h0, mode}, 8'h01);
            other_req_pending = 1'b1;
            wait_mode(LPM_ACTIVE);
            other_req_pending = 1'b0;
            wr(sa[i], fbit[i] | mbit[i], 4'h0);
            r = $random(seed);
            g = r[0];
            wr(ADDR_GATE, 4'h1, {3'h0, g});
            pulse(standby_instruction);
            cyc(3);
            fire(i);
            wait_mode(LPM_ACTIVE);
            check({4'h0, seen}, {4'h0, 1'b1, g, 2'b00});
            wr(sa[i], fbit[i] | mbit[i], mbit[i]);
            wr(ADDR_GATE, 4'h1, 4'h0);
        end
        $display("test standby done");
        // pending request turns both into no-ops
        other_req_pending = 1'b1;
        pulse(stop_instruction);
        check({5'h0, mode, instr_nop}, 8'h01);
        pulse(standby_instruction);
        check({5'h0, mode, instr_nop}, 8'h01);
        other_req_pending = 1'b0;
        hold_len = 10'h0FA;
        pulse(hold_start);
        cyc(255);
        check({6'h0, mode}, 8'h00);
        clk_sel_strap = 1'b0;
        pulse(stop_instruction);
        check({instr_clk_en, comparator_halt, mode, osc_en, periph_reset, pins_hiz,
            pin_func_cancel}, 8'h67);
        cyc(5);
        hold_len = 10'(STAB_CYCLES + 2);
        pulse(hold_start);
        wait_mode(LPM_ACTIVE);
        check({4'h0, seen}, 8'h02);
        check({7'h0, div_fast}, 8'h00);
        count_ticks(64, DIV_SLOW);
        rd(ADDR_RETAIN, 5'h18);
        $display("test stop cancel done");
        // reset out of stop and standby; strap stays low
        pulse(stop_instruction);
        cyc(10);
        do_reset();
        rd(ADDR_RETAIN, 5'h10);
        check({7'h0, div_fast}, 8'h00);
        wr(ADDR_GATE, 4'h1, 4'h1);
        pulse(standby_instruction);
        cyc(5);
        do_reset();
        rd(ADDR_GATE, 5'h10);
        cyc(2);
        $display("test reset exits done");
        print_verdict();
    end

    // Whole run is under a thousand cycles
    initial begin
        cyc(20000);
        num_errors++;
        print_verdict();
    end
endmodule
`default_nettype wire
